// ===== hw/asa_pkg.sv
// Constants and types for the alarm status aggregator
// Behaviour
// - Module alarm sinks when no severe error; floats on severe error or board absent.
// - Each info alarm sinks for green or orange indicator, floats for red.
// - Module alarm sinks when status indicator green, floats when red.
// - Status red when faulty or initializing, green when good, dark unpowered.
// - Info one ORs equalizer alarms: all red, some orange, none green.
// - Info two ORs reclocker alarms: all red, some orange, none green.
// - Info three is unused and held constantly dark.
// - Bypassed reclocker with known rate reports locked and actual rate.
// - Bypassed reclocker without known rate reports bypass and no rate.
// - Alarm outputs are open drain: sink or float, never drive high.
// - Four independent streams are counted when choosing colours.
package asa_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int unsigned NUM_STREAMS = 4;
    localparam int unsigned RATE_W      = 3;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ASA_LED_OFF,
        ASA_LED_RED,
        ASA_LED_ORANGE,
        ASA_LED_GREEN
    } asa_led_t;

    typedef enum logic [1:0] {
        ASA_RPT_UNLOCKED,
        ASA_RPT_LOCKED,
        ASA_RPT_BYPASS
    } asa_rpt_t;

    typedef struct packed {
        logic [NUM_STREAMS-1:0] eq_los;
        logic [NUM_STREAMS-1:0] rc_lol;
        logic [NUM_STREAMS-1:0] rc_bypass;
        logic [NUM_STREAMS-1:0] rate_known;
    } asa_flags_t;

    localparam logic [RATE_W-1:0] RATE_NONE = 3'h0;

endpackage

// ===== hw/asa_top.sv
// Alarm aggregation: indicators, open-drain alarms and controller lock report
`timescale 1ns/1ps
module asa_top (
    input  wire logic                                   sys_clk,
    input  wire logic                                   reset_n,
    input  wire logic                                   power_good,
    input  wire logic                                   board_present,
    input  wire logic                                   module_fault,
    input  wire logic                                   init_done,
    input  wire asa_pkg::asa_flags_t                    flags_in,
    input  wire logic [asa_pkg::NUM_STREAMS*asa_pkg::RATE_W-1:0] rate_in,
    output asa_pkg::asa_led_t                           led_status,
    output asa_pkg::asa_led_t                           led_info1,
    output asa_pkg::asa_led_t                           led_info2,
    output asa_pkg::asa_led_t                           led_info3,
    output logic                                        alm_module_dat,
    output logic                                        alm_module_oe,
    output logic                                        alm_info1_dat,
    output logic                                        alm_info1_oe,
    output logic                                        alm_info2_dat,
    output logic                                        alm_info2_oe,
    output asa_pkg::asa_rpt_t [asa_pkg::NUM_STREAMS-1:0] rpt_state,
    output logic [asa_pkg::NUM_STREAMS*asa_pkg::RATE_W-1:0] rpt_rate
);

    localparam int unsigned N = asa_pkg::NUM_STREAMS;
    localparam int unsigned W = asa_pkg::RATE_W;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Alarm sources come from other chips; two stages each
    localparam int unsigned SW = $bits(asa_pkg::asa_flags_t) + 4 + N*W;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {flags_in, rate_in, power_good, board_present, module_fault, init_done};
            sync2_r <= sync1_r;
        end
    end

    asa_pkg::asa_flags_t fl;
    logic [N*W-1:0]      rate_s;
    logic                pwr_s;
    logic                brd_s;
    logic                flt_s;
    logic                ini_s;
    assign {fl, rate_s, pwr_s, brd_s, flt_s, ini_s} = sync2_r;

    // ----------------------------------------
    // Indicator colours
    // ----------------------------------------
    function automatic asa_pkg::asa_led_t info_colour(input logic [N-1:0] alm);
        if (&alm) begin
            info_colour = asa_pkg::ASA_LED_RED;
        end else if (|alm) begin
            info_colour = asa_pkg::ASA_LED_ORANGE;
        end else begin
            info_colour = asa_pkg::ASA_LED_GREEN;
        end
    endfunction

    asa_pkg::asa_led_t status_nxt;
    always_comb begin
        if (!pwr_s) begin
            status_nxt = asa_pkg::ASA_LED_OFF;
        end else if (flt_s || !ini_s || !brd_s) begin
            status_nxt = asa_pkg::ASA_LED_RED;
        end else begin
            status_nxt = asa_pkg::ASA_LED_GREEN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            led_status <= asa_pkg::ASA_LED_RED;
            led_info1  <= asa_pkg::ASA_LED_RED;
            led_info2  <= asa_pkg::ASA_LED_RED;
            led_info3  <= asa_pkg::ASA_LED_OFF;
        end else begin
            led_status <= status_nxt;
            led_info1  <= info_colour(fl.eq_los);
            led_info2  <= info_colour(fl.rc_lol);
            led_info3  <= asa_pkg::ASA_LED_OFF;
        end
    end

    // ----------------------------------------
    // Open-drain alarms
    // ----------------------------------------
    // data tied low, only enable moves
    assign alm_module_dat = 1'b0;
    assign alm_info1_dat  = 1'b0;
    assign alm_info2_dat  = 1'b0;

    assign alm_module_oe = (led_status == asa_pkg::ASA_LED_GREEN);
    assign alm_info1_oe  = (led_info1 == asa_pkg::ASA_LED_GREEN) || (led_info1 == asa_pkg::ASA_LED_ORANGE);
    assign alm_info2_oe  = (led_info2 == asa_pkg::ASA_LED_GREEN) || (led_info2 == asa_pkg::ASA_LED_ORANGE);

    // ----------------------------------------
    // Controller lock report
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_rpt
            always_ff @(posedge sys_clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    rpt_state[g]          <= asa_pkg::ASA_RPT_UNLOCKED;
                    rpt_rate[g*W +: W]    <= asa_pkg::RATE_NONE;
                end else if (fl.rc_bypass[g]) begin
                    if (fl.rate_known[g]) begin
                        rpt_state[g]       <= asa_pkg::ASA_RPT_LOCKED;
                        rpt_rate[g*W +: W] <= rate_s[g*W +: W];
                    end else begin
                        rpt_state[g]       <= asa_pkg::ASA_RPT_BYPASS;
                        rpt_rate[g*W +: W] <= asa_pkg::RATE_NONE;
                    end
                end else begin
                    rpt_state[g]       <= fl.rc_lol[g] ? asa_pkg::ASA_RPT_UNLOCKED : asa_pkg::ASA_RPT_LOCKED;
                    rpt_rate[g*W +: W] <= fl.rc_lol[g] ? asa_pkg::RATE_NONE : rate_s[g*W +: W];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Absent board floats module alarm
    board_absent_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        !brd_s |=> !alm_module_oe) else $error("module alarm sinks with board absent");
    module_mirror_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        alm_module_oe == (led_status == asa_pkg::ASA_LED_GREEN)) else $error("module alarm not mirroring");
    info_red_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (led_info1 == asa_pkg::ASA_LED_RED) |-> !alm_info1_oe) else $error("info1 sinks while red");
    fault_red_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (pwr_s && flt_s) |=> led_status == asa_pkg::ASA_LED_RED) else $error("fault not red");
    eq_all_red_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (&fl.eq_los) |=> led_info1 == asa_pkg::ASA_LED_RED) else $error("info1 not red");
    rc_part_orange_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (|fl.rc_lol && !(&fl.rc_lol)) |=> led_info2 == asa_pkg::ASA_LED_ORANGE) else $error("info2 not orange");
    info3_dark_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        led_info3 == asa_pkg::ASA_LED_OFF) else $error("info3 lit");
    byp_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (fl.rc_bypass[0] && fl.rate_known[0]) |=> rpt_state[0] == asa_pkg::ASA_RPT_LOCKED)
        else $error("bypass with rate not locked");
    byp_norate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (fl.rc_bypass[0] && !fl.rate_known[0]) |=> rpt_rate[W-1:0] == asa_pkg::RATE_NONE)
        else $error("bypass reports rate");
    never_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        !alm_module_dat && !alm_info1_dat && !alm_info2_dat) else $error("alarm drives high");
    no_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (fl.eq_los == '0) |=> led_info1 == asa_pkg::ASA_LED_GREEN) else $error("info1 latched");

    // ----------------------------------------
    // Status and module alarm
    // ----------------------------------------
    // Healthy module green
    status_green_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (pwr_s && brd_s && !flt_s && ini_s) |=> led_status == asa_pkg::ASA_LED_GREEN)
        else $error("status not green");
    status_dark_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        !pwr_s |=> led_status == asa_pkg::ASA_LED_OFF)
        else $error("status lit without power");
    status_init_red_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (pwr_s && !ini_s) |=> led_status == asa_pkg::ASA_LED_RED)
        else $error("status not red while initialising");
    module_sink_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (pwr_s && brd_s && !flt_s && ini_s) |=> alm_module_oe)
        else $error("module alarm floats while healthy");
    fault_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        flt_s |=> !alm_module_oe)
        else $error("module alarm sinks on fault");
    reset_float_a: assert property (@(posedge sys_clk)
        !rst_n_r |-> !alm_module_oe && !alm_info1_oe && !alm_info2_oe)
        else $error("alarm sinks during reset");

    // ----------------------------------------
    // Info indicators and alarms
    // ----------------------------------------
    // Info two floats on red
    info2_red_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (led_info2 == asa_pkg::ASA_LED_RED) |-> !alm_info2_oe)
        else $error("info2 sinks while red");
    info1_sink_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (led_info1 inside {asa_pkg::ASA_LED_GREEN, asa_pkg::ASA_LED_ORANGE}) |-> alm_info1_oe)
        else $error("info1 floats while green or orange");
    info2_sink_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (led_info2 inside {asa_pkg::ASA_LED_GREEN, asa_pkg::ASA_LED_ORANGE}) |-> alm_info2_oe)
        else $error("info2 floats while green or orange");
    eq_all_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (&fl.eq_los) |=> !alm_info1_oe)
        else $error("info1 alarm sinks with all signals lost");
    rc_lock_sink_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (fl.rc_lol == '0) |=> alm_info2_oe)
        else $error("info2 alarm floats with all locked");
    eq_part_orange_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (|fl.eq_los && !(&fl.eq_los)) |=> led_info1 == asa_pkg::ASA_LED_ORANGE)
        else $error("info1 not orange");
    eq_one_orange_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        $onehot(fl.eq_los) |=> led_info1 == asa_pkg::ASA_LED_ORANGE)
        else $error("info1 ignores single loss");
    rc_all_red_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (&fl.rc_lol) |=> led_info2 == asa_pkg::ASA_LED_RED)
        else $error("info2 not red");
    rc_none_green_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        (fl.rc_lol == '0) |=> led_info2 == asa_pkg::ASA_LED_GREEN)
        else $error("info2 not green");
    rc_three_orange_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ($countones(fl.rc_lol) == N - 1) |=> led_info2 == asa_pkg::ASA_LED_ORANGE)
        else $error("info2 not orange with one lock left");

    // ----------------------------------------
    // Per-stream lock report
    // ----------------------------------------
    for (genvar s = 0; s < N; s++) begin : g_rpt_chk
        lock_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (fl.rc_bypass[s] && fl.rate_known[s]) |=> rpt_state[s] == asa_pkg::ASA_RPT_LOCKED)
            else $error("bypass with rate not locked");
        lock_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (fl.rc_bypass[s] && fl.rate_known[s]) |=> rpt_rate[s*W +: W] == $past(rate_s[s*W +: W]))
            else $error("bypass rate not reported");
        byp_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (fl.rc_bypass[s] && !fl.rate_known[s]) |=> rpt_state[s] == asa_pkg::ASA_RPT_BYPASS)
            else $error("bypass state not reported");
        byp_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (fl.rc_bypass[s] && !fl.rate_known[s]) |=> rpt_rate[s*W +: W] == asa_pkg::RATE_NONE)
            else $error("bypass reports a rate");
        live_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (!fl.rc_bypass[s] && !fl.rc_lol[s]) |=> rpt_state[s] == asa_pkg::ASA_RPT_LOCKED
                && rpt_rate[s*W +: W] == $past(rate_s[s*W +: W]))
            else $error("live lock not reported");
        lost_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
            (!fl.rc_bypass[s] && fl.rc_lol[s]) |=> rpt_state[s] == asa_pkg::ASA_RPT_UNLOCKED
                && rpt_rate[s*W +: W] == asa_pkg::RATE_NONE)
            else $error("lost lock not reported");
    end

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    green_cov: cover property (@(posedge sys_clk) led_status == asa_pkg::ASA_LED_GREEN);
    orange_cov: cover property (@(posedge sys_clk) led_info1 == asa_pkg::ASA_LED_ORANGE);
    bypass_cov: cover property (@(posedge sys_clk) rpt_state[0] == asa_pkg::ASA_RPT_BYPASS);
    red_info2_cov: cover property (@(posedge sys_clk) led_info2 == asa_pkg::ASA_LED_RED);
    dark_cov: cover property (@(posedge sys_clk) led_status == asa_pkg::ASA_LED_OFF);

endmodule // asa_top

// ===== verif/asa_alarm_wiring.sv
// Far-side alarm wiring model: pulled-up open-drain lines seen by a control system
`timescale 1ns/1ps
module asa_alarm_wiring (
    input  wire logic alm_module_dat,
    input  wire logic alm_module_oe,
    input  wire logic alm_info1_dat,
    input  wire logic alm_info1_oe,
    input  wire logic alm_info2_dat,
    input  wire logic alm_info2_oe,
    output logic      pin_module,
    output logic      pin_info1,
    output logic      pin_info2
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    // pull-up when floating; a driven 1 would show as high too, so the bench also checks oe
    assign pin_module = alm_module_oe ? alm_module_dat : 1'b1;
    assign pin_info1  = alm_info1_oe ? alm_info1_dat : 1'b1;
    assign pin_info2  = alm_info2_oe ? alm_info2_dat : 1'b1;
endmodule // asa_alarm_wiring

// ===== verif/asa_top_test.sv
// Self-checking bench for the alarm status aggregator
`timescale 1ns/1ps
module asa_top_test;
    logic                                    sys_clk;
    logic                                    reset_n;
    logic                                    power_good;
    logic                                    board_present;
    logic                                    module_fault;
    logic                                    init_done;
    asa_pkg::asa_flags_t                     flags_in;
    logic [11:0]                             rate_in;
    asa_pkg::asa_led_t                       led_status;
    asa_pkg::asa_led_t                       led_info1;
    asa_pkg::asa_led_t                       led_info2;
    asa_pkg::asa_led_t                       led_info3;
    logic                                    alm_module_dat;
    logic                                    alm_module_oe;
    logic                                    alm_info1_dat;
    logic                                    alm_info1_oe;
    logic                                    alm_info2_dat;
    logic                                    alm_info2_oe;
    asa_pkg::asa_rpt_t [3:0]                 rpt_state;
    logic [11:0]                             rpt_rate;
    logic                                    pin_module;
    logic                                    pin_info1;
    logic                                    pin_info2;
    int                                      bad_count = 0;
    int                                      n_compared = 0;

    asa_top asa_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .power_good(power_good),
        .board_present(board_present), .module_fault(module_fault), .init_done(init_done),
        .flags_in(flags_in), .rate_in(rate_in), .led_status(led_status), .led_info1(led_info1),
        .led_info2(led_info2), .led_info3(led_info3), .alm_module_dat(alm_module_dat),
        .alm_module_oe(alm_module_oe), .alm_info1_dat(alm_info1_dat), .alm_info1_oe(alm_info1_oe),
        .alm_info2_dat(alm_info2_dat), .alm_info2_oe(alm_info2_oe), .rpt_state(rpt_state), .rpt_rate(rpt_rate));
    asa_alarm_wiring asa_alarm_wiring_inst (.alm_module_dat(alm_module_dat), .alm_module_oe(alm_module_oe),
        .alm_info1_dat(alm_info1_dat), .alm_info1_oe(alm_info1_oe), .alm_info2_dat(alm_info2_dat),
        .alm_info2_oe(alm_info2_oe), .pin_module(pin_module), .pin_info1(pin_info1), .pin_info2(pin_info2));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Three edges of latency plus margin; inputs then change 1 ns after an edge
    task automatic settle;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    function automatic asa_pkg::asa_led_t exp_led(input int n);
        return (n == 0) ? asa_pkg::ASA_LED_GREEN : (n == 4) ? asa_pkg::ASA_LED_RED : asa_pkg::ASA_LED_ORANGE;
    endfunction

    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_status;
        logic [3:0] cfg [6] = '{4'hd, 4'h5, 4'hf, 4'hc, 4'h9, 4'hd};
        for (int i = 0; i < 6; i++) begin
            {power_good, board_present, module_fault, init_done} = cfg[i];
            settle();
            check("led_status", led_status, (i == 1) ? asa_pkg::ASA_LED_OFF :
                  (cfg[i] == 4'hd) ? asa_pkg::ASA_LED_GREEN : asa_pkg::ASA_LED_RED);
            check("pin_module", {alm_module_oe, pin_module}, (cfg[i] == 4'hd) ? 2'h2 : 2'h1);
        end
    endtask

    task automatic t_info;
        logic [3:0] pat [5] = '{4'h0, 4'h1, 4'h6, 4'he, 4'hf};
        for (int i = 0; i < 5; i++) begin
            flags_in.eq_los = pat[i];
            flags_in.rc_lol = pat[4-i];
            flags_in.rc_bypass = 4'h0;
            settle();
            check("led_info1", led_info1, exp_led(i));
            check("led_info2", led_info2, exp_led(4 - i));
            check("pin_info1", {alm_info1_oe, pin_info1}, (i == 4) ? 2'h1 : 2'h2);
            check("pin_info2", {alm_info2_oe, pin_info2}, (i == 0) ? 2'h1 : 2'h2);
            check("led_info3", led_info3, asa_pkg::ASA_LED_OFF);
        end
    endtask

    task automatic t_bypass;
        logic [3:0]  known [2] = '{4'h5, 4'h2};
        logic [7:0]  st [2]    = '{8'h19, 8'h16};
        logic [11:0] rt [2]    = '{12'h102, 12'h118};
        for (int i = 0; i < 2; i++) begin
            flags_in = '{eq_los: 4'h0, rc_lol: 4'ha, rc_bypass: 4'h3, rate_known: known[i]};
            rate_in = {3'h5, 3'h4, 3'h3, 3'h2};
            settle();
            check("rpt_state", rpt_state, st[i]);
            check("rpt_rate", rpt_rate, rt[i]);
            check("led_info1", led_info1, asa_pkg::ASA_LED_GREEN);
        end
    endtask

    task automatic t_reset;
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("led_status", led_status, asa_pkg::ASA_LED_RED);
        check("rpt_state", rpt_state, 8'h00);
        check("pin_module", pin_module, 1'b1);
        reset_n = 1'b1;
        settle();
        check("led_status", led_status, asa_pkg::ASA_LED_GREEN);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        {power_good, board_present, module_fault, init_done} = 4'hc;
        flags_in = '0;
        rate_in = 12'h000;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        settle();
        t_status();
        t_info();
        t_bypass();
        t_reset();
        conclude();
    end
endmodule // asa_top_test
